// ===== afic_cache_mem.sv
// Contract
// - Command EAh writes every cached sector to the media before completing.
// - Busy stays set until all cached sectors are stored or one fails.
// - A successful flush ends with ready and seek-complete set, busy clear.
// - Without flush support the EAh command is answered as aborted.
// - On a failed media write, abort and load the 48-bit failing sector address.
// - The next flush resumes at the sector after the one that failed.
// - Command ECh returns the parameter block through the sector read handshake.
// - Reserved bits and words of the parameter block read as zero.
// - Word 0 holds 0040h.
// - Words 10 to 19 hold the serial number, 20 ASCII bytes, right justified.
// - Words 23 to 26 hold firmware revision, first character in the high byte.
// - Word 47 holds 8001h.
// - Word 53 holds 0007h.
// - Words 57 and 58 hold current capacity, low half first.
// - Word 59 holds the multiple-sector setting, reset 0101h, tracks host changes.
// - Words 60 and 61 hold the sector count reachable with 28-bit addressing.
// - Word 63 holds multiword DMA support and the current selection.
// - Word 64 holds 0003h.
// - Word 75 holds 001fh.
// - Word 88 holds 407Fh at reset and follows the selected ultra DMA mode.
// - Words 100 to 103 hold the 48-bit user addressable sector count.
`timescale 1ns/1ns

package afic_pkg;

  // Commands
  localparam logic [7:0] CMD_FLUSH_EXT = 8'hea;
  localparam logic [7:0] CMD_IDENTIFY = 8'hec;

  // Register byte offsets
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_ERROR = 8'h04;
  localparam logic [7:0] OFF_LBA_LO = 8'h0c;
  localparam logic [7:0] OFF_LBA_HI = 8'h10;
  localparam logic [7:0] OFF_DEVICE = 8'h14;
  localparam logic [7:0] OFF_CMD_STAT = 8'h18;
  localparam logic [7:0] OFF_CONFIG = 8'h1c;
  localparam logic [7:0] OFF_CACHE = 8'h20;

  // Status, error and device bit positions
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_ABRT = 2;
  localparam int DEV_SEL_BIT = 4;

  // Reset values
  localparam logic [7:0] DEV_RST = 8'he0;
  localparam logic [7:0] MULT_RST = 8'h01;
  localparam logic [7:0] MDMA_RST = 8'h00;
  localparam logic [7:0] UDMA_RST = 8'h40;

  // Parameter block fixed fields
  localparam logic [15:0] ID_W0 = 16'h0040;
  localparam logic [15:0] ID_W47 = 16'h8001;
  localparam logic [15:0] ID_W53 = 16'h0007;
  localparam logic [15:0] ID_W64 = 16'h0003;
  localparam logic [15:0] ID_W75 = 16'h001f;
  localparam logic [7:0] ID_W59_VALID = 8'h01;
  localparam logic [7:0] ID_W63_SUP = 8'h07;
  localparam logic [7:0] ID_W88_SUP = 8'h7f;
  localparam logic [7:0] ID_LAST_WORD = 8'hff;
  localparam logic [15:0] CHS_CYL = 16'h3fff;
  localparam logic [15:0] CHS_HEADS = 16'h0010;
  localparam logic [15:0] CHS_SPT = 16'h003f;
  localparam logic [47:0] LBA28_MAX = 48'h0000_0fff_ffff;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } afic_wb_req_s;

  typedef enum {
    ST_IDLE,
    ST_FL_RD,
    ST_FL_LOAD,
    ST_FL_REQ,
    ST_ID_PREP,
    ST_ID_XFER
  } afic_state_e;

endpackage

////////////////////////////////////////////////////////////////////////////////

module afic_cache_mem #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input wire logic clk_i, // Core clock
  input wire logic we_i, // Write strobe
  input wire logic [$clog2(DEPTH)-1:0] waddr_i, // Write address
  input wire logic [WIDTH-1:0] wdata_i, // Write data
  input wire logic [$clog2(DEPTH)-1:0] raddr_i, // Read address
  output logic [WIDTH-1:0] rdata_o // Registered read data
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // Contents need no reset: only entries between the pointers are ever used
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end

endmodule // afic_cache_mem

// ===== afic_top.sv
`timescale 1ns/1ns

module afic_top #(
  parameter int DEPTH = 16,
  parameter bit FLUSH_EXT_SUPPORTED = 1'b1,
  parameter bit DRIVE_NUM = 1'b0,
  parameter logic [47:0] CAPACITY = 48'h0000_3800_0000,
  parameter logic [159:0] SERIAL = {20{8'h30}}, // Arbitrary value
  parameter logic [63:0] FIRMWARE = {8{8'h31}}, // Arbitrary value
  parameter logic [319:0] MODEL = {40{8'h20}} // Arbitrary value
) (
  input wire logic clk_i, // 100 MHz clock
  input wire logic rst_n_i, // Async reset, active low
  input wire afic_pkg::afic_wb_req_s wb_i, // Wishbone request
  output logic wb_ack_o, // Wishbone ack
  output logic [31:0] wb_dat_o, // Wishbone read data
  input wire logic cache_push_i, // Cache fill strobe
  input wire logic [47:0] cache_lba_i, // Sector address being cached
  output logic cache_rdy_o, // Cache accepts a sector
  output logic media_req_o, // Media write request
  output logic [47:0] media_lba_o, // Sector being stored
  input wire logic media_ack_i, // Media write done pulse
  input wire logic media_err_i // Unrecoverable error with ack
);
  import afic_pkg::*;

  localparam int PW = $clog2(DEPTH);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter block lookup

  function automatic logic [15:0] id_word(input logic [7:0] w, input logic [7:0] mult,
                                          input logic [7:0] mdma, input logic [7:0] udma);
    logic [15:0] r;
    logic [31:0] cur;
    logic [47:0] lba28;
    int n;
    r = 16'h0000;
    cur = 32'(CHS_CYL) * 32'(CHS_HEADS) * 32'(CHS_SPT);
    lba28 = (CAPACITY > LBA28_MAX) ? LBA28_MAX : CAPACITY;
    n = int'(w);
    if (n >= 10 && n <= 19) begin
      r = SERIAL[159 - 16 * (n - 10) -: 16];
    end else if (n >= 23 && n <= 26) begin
      r = FIRMWARE[63 - 16 * (n - 23) -: 16];
    end else if (n >= 27 && n <= 46) begin
      r = MODEL[319 - 16 * (n - 27) -: 16];
    end else if (n >= 100 && n <= 103) begin
      r = CAPACITY[16 * (n - 100) +: 16] & {16{n != 103}};
    end else begin
      case (w)
        8'h00: r = ID_W0;
        8'h01: r = CHS_CYL;
        8'h02: r = 16'hc837;
        8'h03: r = CHS_HEADS;
        8'h05: r = 16'h0240;
        8'h06: r = CHS_SPT;
        8'h16: r = 16'h0004;
        8'h2f: r = ID_W47;
        8'h31: r = 16'h0f00;
        8'h32: r = 16'h4000;
        8'h33: r = 16'h0200;
        8'h35: r = ID_W53;
        8'h36: r = CHS_CYL;
        8'h37: r = CHS_HEADS;
        8'h38: r = CHS_SPT;
        8'h39: r = cur[15:0];
        8'h3a: r = cur[31:16];
        8'h3b: r = {ID_W59_VALID, mult};
        8'h3c: r = lba28[15:0];
        8'h3d: r = lba28[31:16];
        8'h3f: r = {mdma, ID_W63_SUP};
        8'h40: r = ID_W64;
        8'h41, 8'h42, 8'h43, 8'h44: r = 16'h0078;
        8'h4b: r = ID_W75;
        8'h4c: r = 16'h0306;
        8'h4e: r = 16'h0048;
        8'h4f: r = 16'h0040;
        8'h50: r = 16'h03f0;
        8'h52: r = 16'h742b;
        8'h53: r = 16'h7501;
        8'h54, 8'h57: r = 16'h4020;
        8'h55: r = 16'h7429;
        8'h56: r = 16'h3401;
        8'h58: r = {udma, ID_W88_SUP};
        8'h59: r = 16'h0003;
        8'h5c: r = 16'hfffe;
        default: r = 16'h0000;
      endcase
    end
    return r;
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  afic_state_e state_q, state_d;
  logic [PW:0] rd_ptr_q, rd_ptr_d;
  logic [PW:0] wr_ptr_q, wr_ptr_d;
  logic [7:0] widx_q, widx_d;
  logic err_q, err_d;
  logic [47:0] lba_q, lba_d;
  logic [7:0] dev_q, dev_d;
  logic [7:0] mult_q, mult_d;
  logic [7:0] mdma_q, mdma_d;
  logic [7:0] udma_q, udma_d;
  logic ack_q, ack_d;
  logic [31:0] dat_q, dat_d;
  logic media_req_q, media_req_d;
  logic [47:0] media_lba_q, media_lba_d;
  logic cache_rdy_q, cache_rdy_d;
  logic [47:0] mem_rdata;
  logic push;
  logic wb_hit;
  logic data_rd;
  logic [7:0] status;
  logic [PW:0] level;

  afic_cache_mem #(
    .WIDTH(48),
    .DEPTH(DEPTH)
  ) u_mem (
    .clk_i(clk_i),
    .we_i(push),
    .waddr_i(wr_ptr_q[PW-1:0]),
    .wdata_i(cache_lba_i),
    .raddr_i(rd_ptr_q[PW-1:0]),
    .rdata_o(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_d = state_q;
    rd_ptr_d = rd_ptr_q;
    wr_ptr_d = wr_ptr_q;
    widx_d = widx_q;
    err_d = err_q;
    lba_d = lba_q;
    dev_d = dev_q;
    mult_d = mult_q;
    mdma_d = mdma_q;
    udma_d = udma_q;
    media_req_d = media_req_q;
    media_lba_d = media_lba_q;
    wb_hit = wb_i.cyc & wb_i.stb & ~ack_q;
    ack_d = wb_hit;
    dat_d = 32'h0000_0000;
    push = cache_push_i & cache_rdy_q;
    data_rd = wb_hit & ~wb_i.we & (wb_i.adr == OFF_DATA) & (state_q == ST_ID_XFER);
    level = wr_ptr_q - rd_ptr_q;
    status = 8'h00;
    status[ST_BSY] = (state_q != ST_IDLE) && (state_q != ST_ID_XFER);
    status[ST_RDY] = 1'b1;
    status[ST_DSC] = 1'b1;
    status[ST_DRQ] = (state_q == ST_ID_XFER);
    status[ST_ERR] = err_q;

    if (push) begin
      wr_ptr_d = wr_ptr_q + 1'b1;
    end

    // Register reads
    if (wb_hit && !wb_i.we) begin
      case (wb_i.adr)
        OFF_DATA: dat_d = data_rd ? {16'h0000, id_word(widx_q, mult_q, mdma_q, udma_q)}
                                  : 32'h0000_0000;
        OFF_ERROR: dat_d = {29'h0, err_q, 2'b00};
        OFF_LBA_LO: dat_d = {8'h00, lba_q[23:0]};
        OFF_LBA_HI: dat_d = {8'h00, lba_q[47:24]};
        OFF_DEVICE: dat_d = {24'h0, dev_q};
        OFF_CMD_STAT: dat_d = {24'h0, status};
        OFF_CONFIG: dat_d = {8'h00, udma_q, mdma_q, mult_q};
        OFF_CACHE: dat_d = 32'(level);
        default: dat_d = 32'h0000_0000;
      endcase
    end

    // Identify words leave one per data read, in ascending order
    if (data_rd) begin
      widx_d = widx_q + 8'h01;
      if (widx_q == ID_LAST_WORD) begin
        state_d = ST_IDLE;
      end
    end

    // Register writes; the task file only changes while idle
    if (wb_hit && wb_i.we) begin
      case (wb_i.adr)
        OFF_CONFIG: begin
          {udma_d, mdma_d, mult_d} = 24'(merge({8'h00, udma_q, mdma_q, mult_q},
                                               wb_i.dat, wb_i.sel));
        end
        OFF_LBA_LO: if (state_q == ST_IDLE) begin
          lba_d[23:0] = 24'(merge({8'h00, lba_q[23:0]}, wb_i.dat, wb_i.sel));
        end
        OFF_LBA_HI: if (state_q == ST_IDLE) begin
          lba_d[47:24] = 24'(merge({8'h00, lba_q[47:24]}, wb_i.dat, wb_i.sel));
        end
        OFF_DEVICE: if (state_q == ST_IDLE && wb_i.sel[0]) begin
          dev_d = wb_i.dat[7:0];
        end
        OFF_CMD_STAT: begin
          // Commands for the other drive, or while busy, are ignored
          if (state_q == ST_IDLE && wb_i.sel[0] && dev_q[DEV_SEL_BIT] == DRIVE_NUM) begin
            err_d = 1'b0;
            if (wb_i.dat[7:0] == CMD_FLUSH_EXT) begin
              if (FLUSH_EXT_SUPPORTED) begin
                state_d = ST_FL_RD;
              end else begin
                err_d = 1'b1;
              end
            end else if (wb_i.dat[7:0] == CMD_IDENTIFY) begin
              state_d = ST_ID_PREP;
              widx_d = 8'h00;
            end else begin
              err_d = 1'b1;
            end
          end
        end
        default: ;
      endcase
    end

    // Flush walk: one media write per cached sector
    case (state_q)
      ST_FL_RD: begin
        if (rd_ptr_q == wr_ptr_q) begin
          state_d = ST_IDLE;
        end else begin
          state_d = ST_FL_LOAD;
        end
      end
      ST_FL_LOAD: begin
        media_req_d = 1'b1;
        media_lba_d = mem_rdata;
        state_d = ST_FL_REQ;
      end
      ST_FL_REQ: begin
        if (media_ack_i) begin
          media_req_d = 1'b0;
          rd_ptr_d = rd_ptr_q + 1'b1;
          if (media_err_i) begin
            lba_d = media_lba_q;
            err_d = 1'b1;
            state_d = ST_IDLE;
          end else begin
            state_d = ST_FL_RD;
          end
        end
      end
      ST_ID_PREP: state_d = ST_ID_XFER;
      default: ;
    endcase

    // Filling pauses during commands so the flush sees a fixed set
    cache_rdy_d = (state_d == ST_IDLE) && ((wr_ptr_d - rd_ptr_d) != (PW+1)'(DEPTH));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_IDLE;
      rd_ptr_q <= '0;
      wr_ptr_q <= '0;
      widx_q <= 8'h00;
      err_q <= 1'b0;
      lba_q <= 48'h0;
      dev_q <= DEV_RST;
      mult_q <= MULT_RST;
      mdma_q <= MDMA_RST;
      udma_q <= UDMA_RST;
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      media_req_q <= 1'b0;
      media_lba_q <= 48'h0;
      cache_rdy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rd_ptr_q <= rd_ptr_d;
      wr_ptr_q <= wr_ptr_d;
      widx_q <= widx_d;
      err_q <= err_d;
      lba_q <= lba_d;
      dev_q <= dev_d;
      mult_q <= mult_d;
      mdma_q <= mdma_d;
      udma_q <= udma_d;
      ack_q <= ack_d;
      dat_q <= dat_d;
      media_req_q <= media_req_d;
      media_lba_q <= media_lba_d;
      cache_rdy_q <= cache_rdy_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign media_req_o = media_req_q;
  assign media_lba_o = media_lba_q;
  assign cache_rdy_o = cache_rdy_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  logic cmd_wr;
  assign cmd_wr = wb_hit & wb_i.we & (wb_i.adr == OFF_CMD_STAT) & wb_i.sel[0]
                  & (state_q == ST_IDLE) & (dev_q[DEV_SEL_BIT] == DRIVE_NUM);

  chk_media_hold: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    media_req_q && !media_ack_i |=> media_req_q && $stable(media_lba_q))
    else $error("media request dropped before ack");

  chk_bsy_flush: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    state_q == ST_FL_REQ && !media_ack_i |=> status[ST_BSY])
    else $error("busy cleared during flush");

  chk_flush_done: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    state_q == ST_FL_RD && rd_ptr_q == wr_ptr_q && !err_q
    |=> !status[ST_BSY] && status[ST_RDY] && status[ST_DSC] && !status[ST_ERR])
    else $error("flush did not complete with ready status");

  chk_unsup_abort: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    cmd_wr && wb_i.dat[7:0] == CMD_FLUSH_EXT && !FLUSH_EXT_SUPPORTED
    |=> err_q && state_q == ST_IDLE)
    else $error("unsupported flush not aborted");

  chk_err_lba: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    state_q == ST_FL_REQ && media_ack_i && media_err_i
    |=> err_q && lba_q == $past(media_lba_q) && state_q == ST_IDLE)
    else $error("failing sector address not reported");

  chk_resume: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    state_q == ST_FL_REQ && media_ack_i |=> rd_ptr_q == $past(rd_ptr_q) + 1'b1)
    else $error("flush pointer not past the written sector");

  chk_word0: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    data_rd && widx_q == 8'h00 |=> wb_ack_o && wb_dat_o == {16'h0000, ID_W0})
    else $error("word 0 wrong");

  chk_word59: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    data_rd && widx_q == 8'h3b |=> wb_dat_o[15:0] == {ID_W59_VALID, $past(mult_q)})
    else $error("word 59 does not follow the setting");

  chk_id_end: assert property (@(posedge clk_i) disable iff (!rst_n_q)
    data_rd && widx_q == ID_LAST_WORD |=> state_q == ST_IDLE && !status[ST_BSY])
    else $error("identify did not end after word 255");

endmodule // afic_top

// ===== afic_media_model.sv
`timescale 1ns/1ns

module afic_media_model (
  input wire logic clk_i, // Core clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic req_i, // Media write request
  input wire logic [47:0] lba_i, // Sector being stored
  input wire logic fail_en_i, // Arm unrecoverable failure of every write to fail_lba_i
  input wire logic [47:0] fail_lba_i, // Sector that fails
  output logic ack_o, // Write done pulse
  output logic err_o // Failure, meaningful only with ack
);
  logic [3:0] wait_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_q <= 4'h0;
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end else if (req_i && !ack_o) begin
      // Odd sectors answer slowly so the busy window is stretched
      if (wait_q == (lba_i[0] ? 4'h5 : 4'h0)) begin
        ack_o <= 1'b1;
        err_o <= fail_en_i && (lba_i == fail_lba_i);
        wait_q <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
        err_o <= ~err_o;
      end
    end else begin
      // Error line is meaningless outside ack, so it keeps toggling
      ack_o <= 1'b0;
      err_o <= ~err_o;
      wait_q <= 4'h0;
    end
  end
endmodule // afic_media_model

// ===== testbench.sv
`timescale 1ns/1ns

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end

module testbench;
  import afic_pkg::*;
  localparam logic [47:0] CAP = 48'h0000_3800_0000;
  localparam logic [159:0] SER = "SN0123456789ABCDEFGH";
  localparam logic [63:0] FW = "FW1.02XY";
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  afic_wb_req_s wb_q = '0;
  logic push = 1'b0;
  logic fail_en = 1'b0;
  logic use2 = 1'b0;
  logic ack, ack2, req, mack, merr, crdy;
  logic [31:0] dat, dat2, r, f;
  logic [47:0] lba_in = '0;
  logic [47:0] fail_lba = '0;
  logic [47:0] mlba;
  logic [47:0] pushed[$];
  logic [47:0] stored[$];
  logic [7:0] mult, mdma, udma;
  int fail_count = 0;
  int num_checks = 0;
  int seed = 67672;

  always #5 clk_i = ~clk_i;

  afic_top #(.CAPACITY(CAP), .SERIAL(SER), .FIRMWARE(FW)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_i(wb_q), .wb_ack_o(ack), .wb_dat_o(dat),
    .cache_push_i(push), .cache_lba_i(lba_in), .cache_rdy_o(crdy), .media_req_o(req),
    .media_lba_o(mlba), .media_ack_i(mack), .media_err_i(merr));

  // Second device lacks flush support and only answers on the register bus
  afic_top #(.FLUSH_EXT_SUPPORTED(1'b0)) dut2_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_i(wb_q), .wb_ack_o(ack2), .wb_dat_o(dat2),
    .cache_push_i(1'b0), .cache_lba_i(48'h0), .cache_rdy_o(), .media_req_o(),
    .media_lba_o(), .media_ack_i(1'b0), .media_err_i(1'b0));

  afic_media_model media_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .lba_i(mlba),
    .fail_en_i(fail_en), .fail_lba_i(fail_lba), .ack_o(mack), .err_o(merr));

  always @(posedge clk_i) begin
    if (req === 1'b1 && mack === 1'b1) stored.push_back(mlba);
  end

  ////////////////////////////////////////////////////////////////////////////////

  task automatic summarize;
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n = 0;
    wb_q <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
    do begin
      @(posedge clk_i);
      n++;
    end while ((use2 ? ack2 : ack) !== 1'b1 && n < 50);
    rd = use2 ? dat2 : dat;
    wb_q <= '0;
    if (n >= 50) begin
      fail_count++;
      summarize();
    end
    @(posedge clk_i);
  endtask

  function automatic logic [16:0] id_exp(int w);
    logic [47:0] l28;
    logic [31:0] chs;
    l28 = (CAP > LBA28_MAX) ? LBA28_MAX : CAP;
    chs = 32'(CHS_CYL) * 32'(CHS_HEADS) * 32'(CHS_SPT);
    case (w) inside
      0: return {1'b1, 16'h0040};
      [10:19]: return {1'b1, SER[159 - 16 * (w - 10) -: 16]};
      [23:26]: return {1'b1, FW[63 - 16 * (w - 23) -: 16]};
      47: return {1'b1, 16'h8001};
      53: return {1'b1, 16'h0007};
      57, 58: return {1'b1, chs[16 * (w - 57) +: 16]};
      59: return {1'b1, 8'h01, mult};
      60, 61: return {1'b1, l28[16 * (w - 60) +: 16]};
      63: return {1'b1, mdma, 8'h07};
      64: return {1'b1, 16'h0003};
      75: return {1'b1, 16'h001f};
      88: return {1'b1, udma, 8'h7f};
      [100:102]: return {1'b1, CAP[16 * (w - 100) +: 16]};
      103, 77, [93:99], [104:255]: return {1'b1, 16'h0000};
      default: return 17'h0;
    endcase
  endfunction

  task automatic identify;
    logic [16:0] e;
    wb(1'b1, OFF_CMD_STAT, {24'h0, CMD_IDENTIFY}, r);
    wb(1'b0, OFF_CMD_STAT, 32'h0, r);
    `CHK(r[ST_DRQ], 1'b1)
    for (int w = 0; w < 256; w++) begin
      wb(1'b0, OFF_DATA, 32'h0, r);
      e = id_exp(w);
      if (e[16]) `CHK(r[15:0], e[15:0])
    end
    wb(1'b0, OFF_DATA, 32'h0, r);
    `CHK(r, 32'h0)
    wb(1'b0, OFF_CMD_STAT, 32'h0, r);
    `CHK(r[7:0] & 8'hd9, 8'h50)
  endtask

  task automatic fill(input int n);
    logic [47:0] v;
    `CHK(crdy, 1'b1)
    for (int i = 0; i < n; i++) begin
      v = 48'({$random(seed), $random(seed)});
      push <= 1'b1;
      lba_in <= v;
      pushed.push_back(v);
      @(posedge clk_i);
    end
    push <= 1'b0;
    @(posedge clk_i);
  endtask

  // Returns the first status seen after the command and the final one
  task automatic flush(output logic [31:0] first, output logic [31:0] st);
    int n = 0;
    wb(1'b1, OFF_DEVICE, 32'he0, st);
    wb(1'b1, OFF_CMD_STAT, {24'h0, CMD_FLUSH_EXT}, st);
    do begin
      wb(1'b0, OFF_CMD_STAT, 32'h0, st);
      if (n == 0) first = st;
      n++;
    end while (st[ST_BSY] === 1'b1 && n < 200);
    if (n >= 200) begin
      fail_count++;
      summarize();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////

  initial begin
    mult = 8'h01;
    mdma = 8'h00;
    udma = 8'h40;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wb(1'b0, OFF_CMD_STAT, 32'h0, r);
    `CHK(r[7:0] & 8'hd9, 8'h50)
    identify();
    mult = 8'($random(seed) & 1);
    mdma = 8'h01 << (($random(seed) & 32'hff) % 3);
    udma = 8'h01 << (($random(seed) & 32'hff) % 7);
    wb(1'b1, OFF_CONFIG, {8'h0, udma, mdma, mult}, r);
    identify();
    flush(f, r);
    `CHK(r[7:0] & 8'hd9, 8'h50)
    `CHK(stored.size(), 0)
    fill(5);
    wb(1'b0, OFF_CACHE, 32'h0, r);
    `CHK(r, 32'h0000_0005)
    flush(f, r);
    `CHK(f[ST_BSY], 1'b1)
    `CHK(r[7:0] & 8'hd9, 8'h50)
    `CHK(stored.size(), 5)
    fill(4);
    fail_lba <= pushed[6];
    fail_en <= 1'b1;
    flush(f, r);
    `CHK(r[ST_ERR], 1'b1)
    `CHK(stored.size(), 7)
    wb(1'b0, OFF_ERROR, 32'h0, r);
    `CHK(r[ER_ABRT], 1'b1)
    wb(1'b0, OFF_LBA_LO, 32'h0, r);
    `CHK(r[23:0], fail_lba[23:0])
    wb(1'b0, OFF_LBA_HI, 32'h0, r);
    `CHK(r[23:0], fail_lba[47:24])
    fail_en <= 1'b0;
    flush(f, r);
    `CHK(r[7:0] & 8'hd9, 8'h50)
    `CHK(stored.size(), pushed.size())
    wb(1'b0, OFF_CACHE, 32'h0, r);
    `CHK(r, 32'h0000_0000)
    for (int i = 0; i < pushed.size() && i < stored.size(); i++) begin
      `CHK(stored[i], pushed[i])
    end
    use2 = 1'b1;
    wb(1'b1, OFF_CMD_STAT, {24'h0, CMD_FLUSH_EXT}, r);
    wb(1'b0, OFF_CMD_STAT, 32'h0, r);
    `CHK(r[7:0] & 8'h81, 8'h01)
    wb(1'b0, OFF_ERROR, 32'h0, r);
    `CHK(r[ER_ABRT], 1'b1)
    summarize();
  end
endmodule // testbench
